/* design/fp_compare_flags_unit.sv */
// float compare unit: greater-than exception vector and less-or-equal compare
// assumes the issue stage presents one operation per cycle, synchronous to aclk,
// and an AXI4-Lite master that keeps one read and one write in flight at most
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.

`timescale 1ns/1ps

// Functional notes
// - Opcode 145 returns, one cycle later, the exceptions of source_one > source_two.
// - The vector holds divide-by-zero at bit 0 up to output flush at bit 6, rest zero.
// - The vector operation never changes the status word flags.
// - For the vector operation a denormal input is compared as zero and flagged.
// - The vector result is written only when guard bit 0 is one.
// - Operands are single-precision floats; the vector result is an integer.
// - Opcode 146 returns 1 when source_one is less than or equal to source_two, else 0 (also 0 for a nan).
// - Less-or-equal equals greater-or-equal with the two operands swapped.
// - For less-or-equal a denormal input is compared as zero and flags the status word.
// - Exceptions of less-or-equal set the matching status word flags.
// - Status word flags are sticky and only the status write clears them.
// - Status word flags update on the same edge as the compare result.
// - Each status flag is the OR of its old value (or the status write data when written) and all simultaneous updates.
// - With guard bit 0 clear, less-or-equal changes neither result nor status word.
module fp_compare_flags_unit (
	// clock and reset
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	// issue side
	input  wire fp_cmp_pkg::issue_t             issue_req,
	// status word traffic from other float units and the explicit status write
	input  wire logic [fp_cmp_pkg::FLAG_W-1:0]  other_flags,
	input  wire logic                           psw_write_en,
	input  wire logic [fp_cmp_pkg::FLAG_W-1:0]  psw_write_data,
	// result side
	output fp_cmp_pkg::result_t                 result_ff,
	output logic [fp_cmp_pkg::FLAG_W-1:0]       psw_flags_ff,
	output logic                                irq_ff,
	// axi4-lite write
	input  wire logic [fp_cmp_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	// axi4-lite read
	input  wire logic [fp_cmp_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	fp_cmp_pkg::op_kind_t                 kind;
	fp_cmp_pkg::op_kind_t                 last_kind_ff;
	fp_cmp_pkg::result_t                  nxt_result;
	logic                                 enable_ff;
	logic                                 guard_ok;
	logic                                 fire;
	logic [31:0]                          cmp_x;
	logic [31:0]                          cmp_y;
	logic                                 core_gt;
	logic                                 core_eq;
	logic [fp_cmp_pkg::FLAG_W-1:0]        core_flags;
	logic [fp_cmp_pkg::FLAG_W-1:0]        le_contrib;
	logic [fp_cmp_pkg::FLAG_W-1:0]        nxt_psw;
	logic [fp_cmp_pkg::IRQ_W-1:0]         irq_status_ff;
	logic [fp_cmp_pkg::IRQ_W-1:0]         irq_mask_ff;
	logic [fp_cmp_pkg::IRQ_W-1:0]         events;
	logic [fp_cmp_pkg::IRQ_W-1:0]         irq_clear;
	logic [31:0]                          op_count_ff;
	logic                                 aw_held_ff;
	logic                                 w_held_ff;
	logic [fp_cmp_pkg::ADDR_W-1:0]        awaddr_ff;
	logic [31:0]                          wdata_ff;
	logic [3:0]                           wstrb_ff;
	logic                                 aw_take;
	logic                                 w_take;
	logic                                 b_done;
	logic                                 wr_go;
	logic                                 wr_mapped;
	logic                                 ar_take;
	logic                                 r_done;
	logic [31:0]                          rd_word;
	logic                                 rd_mapped;

	// ****************************************************************
	// decode and operand steering
	// ****************************************************************
	// unknown opcodes belong to other units and are simply not ours
	always_comb begin
		kind = fp_cmp_pkg::OP_IDLE;
		if (issue_req.valid && enable_ff) begin
			unique case (issue_req.opcode)
				fp_cmp_pkg::OPC_GTR_FLAGS: kind = fp_cmp_pkg::OP_GT_FLAGS;
				fp_cmp_pkg::OPC_LEQ:       kind = fp_cmp_pkg::OP_LE_CMP;
				default:                   kind = fp_cmp_pkg::OP_IDLE;
			endcase
		end
	end

	assign guard_ok = issue_req.guard[0];
	assign fire     = (kind != fp_cmp_pkg::OP_IDLE) && guard_ok;

	assign cmp_x = (kind == fp_cmp_pkg::OP_LE_CMP) ? issue_req.source_two : issue_req.source_one;
	assign cmp_y = (kind == fp_cmp_pkg::OP_LE_CMP) ? issue_req.source_one : issue_req.source_two;

	fp_cmp_core u_core (
		.x      (cmp_x),
		.y      (cmp_y),
		.x_gt_y (core_gt),
		.x_eq_y (core_eq),
		.flags  (core_flags)
	);

	// ****************************************************************
	// result register
	// ****************************************************************
	always_comb begin
		nxt_result       = result_ff;
		nxt_result.wr_en = fire;
		if (fire) begin
			nxt_result.dest = issue_req.dest;
			if (kind == fp_cmp_pkg::OP_GT_FLAGS) begin
				nxt_result.data = {25'h000_0000, core_flags};
			end else begin
				nxt_result.data = {31'h0000_0000, core_gt | core_eq};
			end
		end
	end

	// one cycle from issue to result
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_ff    <= '0;
			last_kind_ff <= fp_cmp_pkg::OP_IDLE;
		end else begin
			result_ff    <= nxt_result;
			last_kind_ff <= fire ? kind : fp_cmp_pkg::OP_IDLE;
		end
	end

	// ****************************************************************
	// status word flags
	// ****************************************************************
	// only the compare contributes, never the vector operation
	assign le_contrib = ((kind == fp_cmp_pkg::OP_LE_CMP) && guard_ok) ? core_flags : '0;

	// or-merge with other units; sets win over a simultaneous status write
	// only the explicit write may drop a flag
	assign nxt_psw = (psw_write_en ? psw_write_data : psw_flags_ff) | le_contrib | other_flags;

	// same edge as the result register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			psw_flags_ff <= fp_cmp_pkg::PSW_RST;
		end else begin
			psw_flags_ff <= nxt_psw;
		end
	end

	// ****************************************************************
	// events, interrupt and counter
	// ****************************************************************
	assign events[fp_cmp_pkg::EV_ILLEGAL] = fire & core_flags[fp_cmp_pkg::ILLEGAL_POS];
	assign events[fp_cmp_pkg::EV_FLUSH]   = fire & core_flags[fp_cmp_pkg::IN_FLUSH_POS];
	assign events[fp_cmp_pkg::EV_DONE]    = fire;
	assign irq_clear = (wr_go && awaddr_ff == fp_cmp_pkg::IRQ_ST_OFS && wstrb_ff[0]) ?
		wdata_ff[fp_cmp_pkg::IRQ_W-1:0] : '0;

	// a new event beats a clear in the same cycle; irq lags the status by one edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_ff <= fp_cmp_pkg::IRQ_RST;
			irq_ff        <= 1'b0;
			op_count_ff   <= 32'h0000_0000;
		end else begin
			irq_status_ff <= (irq_status_ff & ~irq_clear) | events;
			irq_ff        <= |(irq_status_ff & irq_mask_ff);
			op_count_ff   <= op_count_ff + {31'h0000_0000, fire};
		end
	end

	// ****************************************************************
	// axi4-lite write path
	// ****************************************************************
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take  = s_axi_wvalid & s_axi_wready;
	assign b_done  = s_axi_bvalid & s_axi_bready;
	assign wr_go   = aw_held_ff & w_held_ff & ~s_axi_bvalid;
	assign wr_mapped = (awaddr_ff == fp_cmp_pkg::CTRL_OFS) || (awaddr_ff == fp_cmp_pkg::PSW_OFS)
		|| (awaddr_ff == fp_cmp_pkg::IRQ_ST_OFS) || (awaddr_ff == fp_cmp_pkg::IRQ_MK_OFS)
		|| (awaddr_ff == fp_cmp_pkg::COUNT_OFS);

	// address and data are caught independently and held until the response is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff    <= 1'b0;
			w_held_ff     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			awaddr_ff     <= '0;
			wdata_ff      <= 32'h0000_0000;
			wstrb_ff      <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_held_ff    <= 1'b1;
				s_axi_awready <= 1'b0;
				awaddr_ff     <= s_axi_awaddr;
			end else if (b_done) begin
				aw_held_ff    <= 1'b0;
				s_axi_awready <= 1'b1;
			end else if (!aw_held_ff) begin
				s_axi_awready <= 1'b1;
			end
			if (w_take) begin
				w_held_ff    <= 1'b1;
				s_axi_wready <= 1'b0;
				wdata_ff     <= s_axi_wdata;
				wstrb_ff     <= s_axi_wstrb;
			end else if (b_done) begin
				w_held_ff    <= 1'b0;
				s_axi_wready <= 1'b1;
			end else if (!w_held_ff) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// writable fields; read-only registers ignore writes with an okay answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_ff    <= fp_cmp_pkg::ENABLE_RST;
			irq_mask_ff  <= fp_cmp_pkg::IRQ_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= fp_cmp_pkg::RESP_OKAY;
		end else begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? fp_cmp_pkg::RESP_OKAY : fp_cmp_pkg::RESP_SLVERR;
				if (awaddr_ff == fp_cmp_pkg::CTRL_OFS && wstrb_ff[0]) begin
					enable_ff <= wdata_ff[0];
				end
				if (awaddr_ff == fp_cmp_pkg::IRQ_MK_OFS && wstrb_ff[0]) begin
					irq_mask_ff <= wdata_ff[fp_cmp_pkg::IRQ_W-1:0];
				end
			end else if (b_done) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// axi4-lite read path
	// ****************************************************************
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign r_done  = s_axi_rvalid & s_axi_rready;

	always_comb begin
		rd_word   = 32'h0000_0000;
		rd_mapped = 1'b1;
		case (s_axi_araddr)
			fp_cmp_pkg::CTRL_OFS:   rd_word = {31'h0000_0000, enable_ff};
			fp_cmp_pkg::PSW_OFS:    rd_word = {25'h000_0000, psw_flags_ff};
			fp_cmp_pkg::IRQ_ST_OFS: rd_word = {29'h0000_0000, irq_status_ff};
			fp_cmp_pkg::IRQ_MK_OFS: rd_word = {29'h0000_0000, irq_mask_ff};
			fp_cmp_pkg::COUNT_OFS:  rd_word = op_count_ff;
			default:                rd_mapped = 1'b0;
		endcase
	end

	// data is captured on the address edge and held until rready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= fp_cmp_pkg::RESP_OKAY;
		end else begin
			if (ar_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_mapped ? fp_cmp_pkg::RESP_OKAY : fp_cmp_pkg::RESP_SLVERR;
			end else if (r_done) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_gt_vector_timing: assert property (
		(kind == fp_cmp_pkg::OP_GT_FLAGS && guard_ok) |=>
		(result_ff.wr_en && result_ff.data[6:0] == $past(core_flags)
		&& result_ff.dest == $past(issue_req.dest)))
		else $error("vector result not written one cycle after issue");
	chk_vector_upper_zero: assert property (
		(result_ff.wr_en && last_kind_ff == fp_cmp_pkg::OP_GT_FLAGS) |->
		(result_ff.data[31:7] == 25'h000_0000 && result_ff.data[1:0] == 2'h0))
		else $error("vector result has bits set outside the compare flags");
	chk_vector_psw_quiet: assert property (
		(kind == fp_cmp_pkg::OP_GT_FLAGS && !psw_write_en && other_flags == '0) |=>
		$stable(psw_flags_ff))
		else $error("vector operation changed the status word");
	chk_vector_flush_bit: assert property (
		(kind == fp_cmp_pkg::OP_GT_FLAGS && guard_ok
		&& issue_req.source_two[30:23] == 8'h00 && issue_req.source_two[22:0] != 23'h00_0000)
		|=> result_ff.data[fp_cmp_pkg::IN_FLUSH_POS])
		else $error("denormal input did not set the flush bit");
	chk_guard_no_write: assert property (
		(kind != fp_cmp_pkg::OP_IDLE && !guard_ok) |=>
		(!result_ff.wr_en && $stable(result_ff.data)))
		else $error("false guard wrote the destination");
	chk_le_ordinary: assert property (
		(kind == fp_cmp_pkg::OP_LE_CMP && guard_ok && !issue_req.source_one[31]
		&& !issue_req.source_two[31] && issue_req.source_one[30:23] != 8'hff
		&& issue_req.source_two[30:23] != 8'hff && issue_req.source_one[30:23] != 8'h00
		&& issue_req.source_two[30:23] != 8'h00) |=>
		(result_ff.data == {31'h0000_0000,
		$past(issue_req.source_one[30:0]) <= $past(issue_req.source_two[30:0])}))
		else $error("less-or-equal gave the wrong answer");
	chk_le_flush_psw: assert property (
		(kind == fp_cmp_pkg::OP_LE_CMP && guard_ok
		&& issue_req.source_two[30:23] == 8'h00 && issue_req.source_two[22:0] != 23'h00_0000)
		|=> (psw_flags_ff[fp_cmp_pkg::IN_FLUSH_POS] && result_ff.wr_en))
		else $error("denormal compare did not flag the status word");
	chk_psw_merge: assert property (
		(kind == fp_cmp_pkg::OP_LE_CMP && guard_ok && !psw_write_en) |=>
		(result_ff.wr_en && psw_flags_ff ==
		($past(psw_flags_ff) | $past(other_flags) | $past(core_flags))))
		else $error("status word not merged on the result edge");
	chk_psw_sticky: assert property (
		!psw_write_en |=> (($past(psw_flags_ff) & ~psw_flags_ff) == '0))
		else $error("status flag dropped without a status write");
	chk_le_guard_quiet: assert property (
		(kind == fp_cmp_pkg::OP_LE_CMP && !guard_ok && !psw_write_en && other_flags == '0)
		|=> ($stable(psw_flags_ff) && !result_ff.wr_en))
		else $error("false guard touched result or status word");
	chk_nan_false: assert property (
		(kind == fp_cmp_pkg::OP_LE_CMP && guard_ok && issue_req.source_two[30:23] == 8'hff
		&& issue_req.source_two[22:0] != 23'h00_0000) |=>
		(result_ff.data == 32'h0000_0000 && psw_flags_ff[fp_cmp_pkg::ILLEGAL_POS]))
		else $error("nan compare not false or not invalid");
	cov_vector_op: cover property (kind == fp_cmp_pkg::OP_GT_FLAGS && guard_ok);
	cov_le_nan:    cover property (fire && core_flags[fp_cmp_pkg::ILLEGAL_POS]);
	cov_irq_high:  cover property (irq_status_ff != '0 ##1 irq_ff);

endmodule : fp_compare_flags_unit

/* include/fp_cmp_pkg.sv */
// shared constants and carrier types for the float compare-and-flags unit
// assumes one core clock at 100 MHz and an AXI4-Lite register port with 32-bit data

package fp_cmp_pkg;

	// ****************************************************************
	// operation codes and timing
	// ****************************************************************
	localparam logic [7:0] OPC_GTR_FLAGS = 8'h91;   // greater-than exception vector
	localparam logic [7:0] OPC_LEQ       = 8'h92;   // less-or-equal compare
	localparam int         OP_LATENCY    = 1;       // issue edge to result edge

	// ****************************************************************
	// exception vector layout, shared by result vector and status word
	// ****************************************************************
	localparam int FLAG_W         = 7;
	localparam int DIV_ZERO_POS   = 0;   // divide_by_zero_flag
	localparam int INEXACT_POS    = 1;   // inexact_flag
	localparam int UNDERFLOW_POS  = 2;   // underflow_flag
	localparam int OVERFLOW_POS   = 3;   // overflow_flag
	localparam int ILLEGAL_POS    = 4;   // illegal_operand_flag
	localparam int IN_FLUSH_POS   = 5;   // input_flushed_zero_flag
	localparam int OUT_FLUSH_POS  = 6;   // output_flushed_zero_flag
	localparam logic [FLAG_W-1:0] PSW_RST = 7'h00;

	// ****************************************************************
	// single-precision field layout
	// ****************************************************************
	localparam int         EXP_LSB  = 23;
	localparam int         EXP_MSB  = 30;
	localparam int         SIGN_POS = 31;
	localparam logic [7:0] EXP_ZERO = 8'h00;
	localparam logic [7:0] EXP_MAX  = 8'hff;

	// ****************************************************************
	// register map, byte addresses
	// ****************************************************************
	localparam int          ADDR_W     = 12;
	localparam logic [11:0] CTRL_OFS   = 12'h000;  // bit 0 unit enable
	localparam logic [11:0] PSW_OFS    = 12'h004;  // status word flags, read only
	localparam logic [11:0] IRQ_ST_OFS = 12'h008;  // sticky events, write one to clear
	localparam logic [11:0] IRQ_MK_OFS = 12'h00c;  // event mask
	localparam logic [11:0] COUNT_OFS  = 12'h010;  // executed operation count
	localparam logic        ENABLE_RST = 1'h1;
	localparam int          IRQ_W      = 3;
	localparam int          EV_ILLEGAL = 0;  // invalid operand seen
	localparam int          EV_FLUSH   = 1;  // denormal input flushed
	localparam int          EV_DONE    = 2;  // guarded operation executed
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ****************************************************************
	// carrier types
	// ****************************************************************
	typedef enum logic [1:0] {OP_IDLE, OP_GT_FLAGS, OP_LE_CMP} op_kind_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  opcode;
		logic [31:0] guard;
		logic [31:0] source_one;
		logic [31:0] source_two;
		logic [6:0]  dest;
	} issue_t;

	typedef struct packed {
		logic        wr_en;
		logic [6:0]  dest;
		logic [31:0] data;
	} result_t;

endpackage : fp_cmp_pkg

/* design/fp_cmp_core.sv */
// combinational single-precision compare with denormal flushing
// assumes operands already ordered by the caller (x is the left side)

`timescale 1ns/1ps

module fp_cmp_core (
	// operands
	input  wire logic [31:0]                     x,
	input  wire logic [31:0]                     y,
	// answers
	output logic                                 x_gt_y,
	output logic                                 x_eq_y,
	output logic [fp_cmp_pkg::FLAG_W-1:0]        flags
);

	logic [31:0] opnd [2];
	logic [30:0] mag [2];
	logic [1:0]  is_den;
	logic [1:0]  is_nan;
	logic [1:0]  is_zero;

	assign opnd[0] = x;
	assign opnd[1] = y;

	// ****************************************************************
	// per-operand classification
	// ****************************************************************
	// single precision fields
	for (genvar i = 0; i < 2; i++) begin : g_opnd
		logic [7:0] expo;
		assign expo = opnd[i][fp_cmp_pkg::EXP_MSB:fp_cmp_pkg::EXP_LSB];
		assign is_den[i] = (expo == fp_cmp_pkg::EXP_ZERO) && (opnd[i][22:0] != 23'h00_0000);
		assign is_nan[i] = (expo == fp_cmp_pkg::EXP_MAX) && (opnd[i][22:0] != 23'h00_0000);
		assign mag[i] = is_den[i] ? 31'h0000_0000 : opnd[i][30:0];
		assign is_zero[i] = (mag[i] == 31'h0000_0000);
	end

	// ordered magnitude compare; +0 and -0 are equal
	always_comb begin
		x_gt_y = 1'b0;
		x_eq_y = 1'b0;
		if (is_nan == 2'b00) begin
			if (is_zero == 2'b11) begin
				x_eq_y = 1'b1;
			end else if (x[fp_cmp_pkg::SIGN_POS] != y[fp_cmp_pkg::SIGN_POS]) begin
				x_gt_y = ~x[fp_cmp_pkg::SIGN_POS];
			end else if (mag[0] == mag[1]) begin
				x_eq_y = 1'b1;
			end else begin
				x_gt_y = x[fp_cmp_pkg::SIGN_POS] ? (mag[0] < mag[1]) : (mag[0] > mag[1]);
			end
		end
	end

	// a compare can only raise invalid and input flush; the rest stay clear
	always_comb begin
		flags = '0;
		flags[fp_cmp_pkg::ILLEGAL_POS]  = |is_nan;
		flags[fp_cmp_pkg::IN_FLUSH_POS] = |is_den;
	end

endmodule : fp_cmp_core

/* verification/cpu_regfile_model.sv */
// partner: destination registers fed by the compare unit's write-back
// assumes at most one result per cycle, taken on its strobe
`timescale 1ns/1ps
module cpu_regfile_model (
	// write-back
	input  wire logic                aclk,
	input  wire fp_cmp_pkg::result_t res,
	// inspection
	input  wire logic [6:0]          rd_idx,
	output logic [31:0]              rd_data
);
	logic [31:0] regs_ff [128];
	// only a strobed result lands, so a guarded-off op leaves its target alone
	always_ff @(posedge aclk) begin
		if (res.wr_en) begin
			regs_ff[res.dest] <= res.data;
		end
	end
	assign rd_data = regs_ff[rd_idx];
endmodule : cpu_regfile_model

/* verification/fp_compare_flags_unit_tb.sv */
// bench: operation tables, status word and register port of the compare unit
// assumes a one-edge result latency and the register file partner
`timescale 1ns/1ps
module fp_compare_flags_unit_tb;
	// ****************
	// bench
	// ****************
	fp_cmp_pkg::issue_t  issue_req;
	fp_cmp_pkg::result_t result_ff;
	logic [6:0]  other_flags, psw_write_data, psw_flags_ff, rd_idx, ep;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        aclk, aresetn, psw_write_en, irq_ff, s_axi_awvalid, s_axi_awready;
	logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, unit_on;
	int          num_errors, total_checks;
	// pairs: ordinary, equal, infinities, nan, denormal
	localparam logic [31:0] SA [8] = '{32'h4040_0000, 32'h4040_0000, 32'h3f80_0000,
		32'h4040_0000, 32'h4040_0000, 32'h7f80_0000, 32'h3f80_0000, 32'h7f80_0000};
	localparam logic [31:0] SB [8] = '{32'h0000_0000, 32'h4040_0000, 32'h4040_0000,
		32'h3f80_0000, 32'hffff_ffff, 32'hff80_0000, 32'h0040_0000, 32'h7f80_0000};
	localparam logic [6:0] FL [8] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h10, 7'h00, 7'h20, 7'h00};
	localparam logic [7:0] LE = 8'h86;  // bit i: pair i is less or equal
	fp_compare_flags_unit fp_compare_flags_unit_inst (.aclk, .aresetn, .issue_req, .other_flags,
		.psw_write_en, .psw_write_data, .result_ff, .psw_flags_ff, .irq_ff, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	cpu_regfile_model cpu_regfile_model_inst (.aclk, .res(result_ff), .rd_idx, .rd_data);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// hang guard, far above the hundred-odd cycles needed
	initial begin
		repeat (3000) @(posedge aclk);
		num_errors++;
		results();
	end
	task chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task results;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results
	// strobe and status at the result edge, target register one edge on
	task op(logic [7:0] c, logic g, logic [31:0] a, b, logic [6:0] d, logic [31:0] ed,
		logic [6:0] es);
		@(posedge aclk);
		issue_req <= '{1'b1, c, {31'h0, g}, a, b, d};
		rd_idx <= d;
		@(posedge aclk);
		issue_req.valid <= 1'b0;
		#1;
		chk("strobe", {31'h0, g & unit_on}, {31'h0, result_ff.wr_en});
		chk("status", {25'h0, es}, {25'h0, psw_flags_ff});
		@(posedge aclk);
		#1;
		chk("register", ed, rd_data);
	endtask : op
	task pw(logic we, logic [6:0] of, es);
		@(posedge aclk);
		psw_write_en <= we;
		other_flags <= of;
		@(posedge aclk);
		psw_write_en <= 1'b0;
		other_flags <= 7'h00;
		#1;
		chk("status", {25'h0, es}, {25'h0, psw_flags_ff});
	endtask : pw
	task wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask : wr
	task rd(logic [11:0] a, logic [1:0] er, logic [31:0] ed);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		chk("rdata", ed, s_axi_rdata);
	endtask : rd
	task t_gtf;  // vector table with status held clear, then guard off
		pw(1'b1, 7'h00, 7'h00);
		for (int i = 0; i < 8; i++) begin
			op(fp_cmp_pkg::OPC_GTR_FLAGS, 1'b1, SA[i], SB[i], 7'(8 + i), {25'h0, FL[i]},
				7'h00);
		end
		op(fp_cmp_pkg::OPC_LEQ, 1'b0, SA[4], SB[4], 7'd12, 32'h0000_0010, 7'h00);
		op(fp_cmp_pkg::OPC_GTR_FLAGS, 1'b0, SA[6], SB[6], 7'd12, 32'h0000_0010, 7'h00);
	endtask : t_gtf
	task t_leq;  // compare table; flags pile up in the status word
		pw(1'b1, 7'h00, 7'h00);
		ep = 7'h00;
		for (int i = 0; i < 8; i++) begin
			ep = ep | FL[i];
			op(fp_cmp_pkg::OPC_LEQ, 1'b1, SA[i], SB[i], 7'(i), {31'h0, LE[i]},
				ep);
		end
	endtask : t_leq
	task t_psw;  // write against simultaneous set, then sticky set
		pw(1'b1, 7'h08, 7'h08);
		op(fp_cmp_pkg::OPC_LEQ, 1'b1, SA[4], SB[4], 7'd20, 32'h0000_0000, 7'h18);
		pw(1'b1, 7'h01, 7'h01);
	endtask : t_psw
	task t_bus;  // register port and interrupt: masked, unmasked, cleared
		rd(fp_cmp_pkg::PSW_OFS, fp_cmp_pkg::RESP_OKAY, 32'h0000_0001);
		rd(12'hff0, fp_cmp_pkg::RESP_SLVERR, 32'h0000_0000);
		chk("irq", 32'h0000_0000, {31'h0, irq_ff});
		wr(fp_cmp_pkg::IRQ_ST_OFS, 32'h0000_0007, fp_cmp_pkg::RESP_OKAY);
		wr(fp_cmp_pkg::IRQ_MK_OFS, 32'h0000_0001, fp_cmp_pkg::RESP_OKAY);
		op(fp_cmp_pkg::OPC_LEQ, 1'b1, SA[4], SB[4], 7'd21, 32'h0000_0000, 7'h11);
		chk("irq", 32'h0000_0001, {31'h0, irq_ff});
		wr(fp_cmp_pkg::IRQ_ST_OFS, 32'h0000_0001, fp_cmp_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("irq", 32'h0000_0000, {31'h0, irq_ff});
		// disabled unit ignores a guarded compare; count holds the 18 executed ops
		wr(fp_cmp_pkg::CTRL_OFS, 32'h0000_0000, fp_cmp_pkg::RESP_OKAY);
		unit_on = 1'b0;
		op(fp_cmp_pkg::OPC_LEQ, 1'b1, SA[1], SB[1], 7'd21, 32'h0000_0000, 7'h11);
		wr(fp_cmp_pkg::CTRL_OFS, 32'h0000_0001, fp_cmp_pkg::RESP_OKAY);
		unit_on = 1'b1;
		rd(fp_cmp_pkg::CTRL_OFS, fp_cmp_pkg::RESP_OKAY, 32'h0000_0001);
		rd(fp_cmp_pkg::COUNT_OFS, fp_cmp_pkg::RESP_OKAY, 32'h0000_0012);
		wr(12'hff0, 32'h0000_0000, fp_cmp_pkg::RESP_SLVERR);
	endtask : t_bus
	initial begin
		num_errors = 0;
		total_checks = 0;
		unit_on = 1'b1;
		aresetn = 1'b0;
		issue_req = '0;
		s_axi_wstrb = 4'hf;
		{psw_write_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{other_flags, psw_write_data, rd_idx, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_gtf();
		t_leq();
		t_psw();
		t_bus();
		results();
	end
endmodule : fp_compare_flags_unit_tb
